//--- hdl/usp_pkg.sv
`default_nettype none
package usp_pkg;
    localparam int unsigned CLK_HZ          = 20_000_000;
    localparam int unsigned STREAM_HZ_LIMIT = 1_250_000;
    localparam int unsigned TICK_GAP_CYC    =
        (CLK_HZ + STREAM_HZ_LIMIT - 1) / STREAM_HZ_LIMIT;
    localparam int          RATE_DIV_W      = 21;
    localparam logic [4:0]  RATE_EXP_MAX    = 5'h14;
    localparam int          FIX_FRAC        = 20;
    localparam logic [15:0] INT16_FS        = 16'h7333;
    localparam int          HDR_BYTES       = 4;
    localparam int          BUF_BYTES       = 20;
    localparam logic [10:0] HDR_LEN         = 11'h004;

    localparam logic [7:0]  REG_CHAN = 8'h00;
    localparam logic [7:0]  REG_RATE = 8'h04;
    localparam logic [7:0]  REG_FMT  = 8'h08;
    localparam logic [7:0]  REG_PKT  = 8'h0c;
    localparam logic [7:0]  REG_PORT = 8'h10;
    localparam logic [7:0]  REG_OPT  = 8'h14;
    localparam logic [7:0]  REG_EN   = 8'h18;
    localparam logic [7:0]  REG_MAXR = 8'h1c;
    localparam logic [7:0]  REG_STAT = 8'h20;

    localparam logic [1:0]  CHAN_RST = 2'h0;
    localparam logic [4:0]  RATE_RST = 5'h00;
    localparam logic        FMT_RST  = 1'h0;
    localparam logic [1:0]  PKT_RST  = 2'h0;
    localparam logic [15:0] PORT_RST = 16'h0749;
    localparam logic [15:0] PORT_MIN = 16'h0400;
    localparam logic [1:0]  OPT_RST  = 2'h2;
    localparam int          OPT_LE   = 0;
    localparam int          OPT_CHK  = 1;

    localparam logic [1:0]  RESP_OK  = 2'h0;
    localparam logic [1:0]  RESP_ERR = 2'h2;

    typedef enum logic [1:0] {
        CH_X = 2'h0, CH_XY = 2'h1, CH_RT = 2'h2, CH_XYRT = 2'h3
    } usp_chan_t;

    typedef enum logic {FMT_F32 = 1'h0, FMT_I16 = 1'h1} usp_fmt_t;

    typedef struct packed {
        logic [31:0]        x_f;
        logic [31:0]        y_f;
        logic [31:0]        r_f;
        logic [31:0]        t_f;
        logic signed [23:0] x_q;
        logic signed [23:0] y_q;
        logic signed [23:0] r_q;
        logic signed [23:0] t_q;
    } usp_demod_t;

    typedef struct packed {
        usp_chan_t   chan;
        logic [4:0]  rate;
        usp_fmt_t    fmt;
        logic [1:0]  pkt;
        logic [15:0] port;
        logic [1:0]  opt;
    } usp_cfg_t;

    typedef struct packed {
        logic [31:0] ip;
        logic [15:0] port;
        logic [10:0] len;
        logic        csum;
    } usp_meta_t;

    function automatic logic [10:0] pkt_data_bytes(input logic [1:0] sel);
        case (sel)
            2'h0:    pkt_data_bytes = 11'h400;
            2'h1:    pkt_data_bytes = 11'h200;
            2'h2:    pkt_data_bytes = 11'h100;
            default: pkt_data_bytes = 11'h080;
        endcase
    endfunction : pkt_data_bytes
endpackage : usp_pkg
`default_nettype wire

//--- hdl/usp_stream_packetizer.sv
// Function
// [R1] Channel code picks X, XY, R-theta or all
// [R2] All quantities sampled at one instant
// [R3] Rate is max rate over two to exponent
// [R4] Max rate input, never above 1.25 MHz
// [R5] Rate readback gives exponent, not hertz
// [R6] Format: float32 four bytes, int16 two
// [R7] Int16 full scale maps to 29491, saturated
// [R8] Data portion 1024, 512, 256 or 128
// [R9] Payload is data size plus four
// [R10] Lost packets never resent; receiver keeps pace
// [R11] Port 1024..65535, default 1865
// [R12] Option bit 0 selects little-endian
// [R13] Option bit 1 enables integrity checking
// [R14] Options reset to two
// [R15] Enable register: 0 stops, 1 starts
// [R16] Settings latched only at off-to-on
// [R17] Destination IP from enabling connection
// [R18] Max rate follows time constant and filter
// [R19] Header holds sequence and active settings
// [R20] Sample-ordered packing, send when full
`timescale 1ns/1ps
`default_nettype none
module usp_stream_packetizer
    import usp_pkg::*;
#(
    parameter int unsigned MIN_GAP = TICK_GAP_CYC
) (
    input  wire logic        aclk,          // System clock
    input  wire logic        aresetn,       // Sync reset
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Byte enables
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Response valid
    input  wire logic        s_axi_bready,  // Response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready,  // Read data ready
    input  wire usp_demod_t  demod_in,      // Demodulator outputs
    input  wire logic        max_rate_tick, // Pulse at max rate
    input  wire logic [31:0] max_rate_hz,   // Max rate in Hz
    input  wire logic [31:0] vxi_src_ip,    // Enabling peer IP
    output logic             tx_valid,      // Payload byte valid
    output logic [7:0]       tx_data,       // Payload byte
    output logic             tx_last,       // Last payload byte
    input  wire logic        tx_ready,      // UDP engine ready
    output usp_meta_t        tx_meta,       // Datagram parameters
    output logic             stream_active  // Stream running
);

    if (MIN_GAP < 1 || MIN_GAP > 255) begin : gen_gap_chk
        $error("MIN_GAP out of range");
    end

    typedef enum logic [2:0] {
        ST_OFF  = 3'b001,
        ST_RUN  = 3'b010,
        ST_STOP = 3'b100
    } usp_state_t;

    ////////////////////////////////////////////////////////////////////////
    usp_cfg_t    cfg_r;
    usp_cfg_t    act_r;
    usp_state_t  state_r;
    logic        en_r;
    logic [7:0]  gap_r;
    logic [RATE_DIV_W-1:0] div_r;
    logic [RATE_DIV_W-1:0] mask;
    logic        acc;
    logic        smp_go;
    logic        take;
    logic        busy;
    logic [7:0]  buf_r [0:BUF_BYTES-1];
    logic [7:0]  nb    [0:BUF_BYTES-1];
    logic [31:0] val   [0:3];
    logic [4:0]  len_r;
    logic [4:0]  ptr_r;
    logic        pend_r;
    logic [10:0] dcnt_r;
    logic [10:0] dcnt_nxt;
    logic [10:0] psize;
    logic [15:0] seq_r;
    logic [15:0] ovr_r;
    logic [2:0]  nval;
    logic [2:0]  bpv;
    logic [4:0]  sbytes;
    logic [4:0]  hoff;
    logic        hdr;
    logic        pend;
    logic [7:0]  waddr_r;
    logic [31:0] wdata_r;
    logic [3:0]  wstrb_r;
    logic [31:0] wv;
    logic        do_wr;

    ////////////////////////////////////////////////////////////////////////
    function automatic logic [15:0] to_i16(input logic signed [23:0] q);
        logic signed [40:0] p;
        logic signed [20:0] s;
        p = $signed({{17{q[23]}}, q}) * $signed({25'h0, INT16_FS}); // R7
        s = 21'(p >>> FIX_FRAC);
        if (s > $signed(21'h007fff)) begin
            to_i16 = 16'h7fff;
        end else if (s < $signed(21'h1f8000)) begin
            to_i16 = 16'h8000;
        end else begin
            to_i16 = s[15:0];
        end
    endfunction : to_i16

    function automatic logic [31:0] pick(input logic [31:0] f,
                                         input logic signed [23:0] q,
                                         input usp_fmt_t fm);
        pick = (fm == FMT_I16) ? {16'h0000, to_i16(q)} : f; // R6
    endfunction : pick

    function automatic logic is_mapped(input logic [7:0] a);
        logic [7:0] w;
        w = {a[7:2], 2'b00};
        is_mapped = (w <= REG_STAT);
    endfunction : is_mapped

    function automatic logic [31:0] reg_val(input logic [7:0] a);
        case ({a[7:2], 2'b00})
            REG_CHAN: reg_val = {30'h0, cfg_r.chan};
            REG_RATE: reg_val = {27'h0, cfg_r.rate};          // R5
            REG_FMT:  reg_val = {31'h0, cfg_r.fmt};
            REG_PKT:  reg_val = {30'h0, cfg_r.pkt};
            REG_PORT: reg_val = {16'h0, cfg_r.port};
            REG_OPT:  reg_val = {30'h0, cfg_r.opt};
            REG_EN:   reg_val = {31'h0, en_r};
            REG_MAXR: reg_val = max_rate_hz;                  // R18
            REG_STAT: reg_val = {seq_r, ovr_r[14:0], stream_active};
            default:  reg_val = 32'h0;
        endcase
    endfunction : reg_val

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write: address and data in either order
    assign do_wr = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b1;
            waddr_r       <= 8'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            s_axi_awready <= 1'b0;
            waddr_r       <= s_axi_awaddr;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_wready <= 1'b1;
            wdata_r      <= 32'h0;
            wstrb_r      <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            s_axi_wready <= 1'b0;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_wready <= 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OK;
        end else if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= is_mapped(waddr_r) ? RESP_OK : RESP_ERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            wv[8*i +: 8] = wstrb_r[i] ? wdata_r[8*i +: 8]
                                      : 8'(reg_val(waddr_r) >> (8*i));
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r.chan <= usp_chan_t'(CHAN_RST);
            cfg_r.rate <= RATE_RST;
            cfg_r.fmt  <= usp_fmt_t'(FMT_RST);
            cfg_r.pkt  <= PKT_RST;
            cfg_r.port <= PORT_RST;                           // R11
            cfg_r.opt  <= OPT_RST;                            // R14
            en_r       <= 1'b0;
        end else if (do_wr) begin
            case ({waddr_r[7:2], 2'b00})
                REG_CHAN: cfg_r.chan <= usp_chan_t'(wv[1:0]);
                REG_RATE: cfg_r.rate <= (wv[31:5] != 27'h0 ||
                                         wv[4:0] > RATE_EXP_MAX)
                                        ? RATE_EXP_MAX : wv[4:0]; // R3
                REG_FMT:  cfg_r.fmt  <= usp_fmt_t'(wv[0]);
                REG_PKT:  cfg_r.pkt  <= wv[1:0];
                REG_PORT: begin
                    // Out-of-range ports leave the old value
                    if (wv[31:16] == 16'h0 && wv[15:0] >= PORT_MIN) begin
                        cfg_r.port <= wv[15:0];               // R11
                    end
                end
                REG_OPT:  cfg_r.opt  <= wv[1:0];
                REG_EN:   en_r       <= wv[0];                // R15
                default:  ;
            endcase
        end
    end

    // AXI4-Lite read
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= RESP_OK;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= reg_val(s_axi_araddr);
            s_axi_rresp   <= is_mapped(s_axi_araddr) ? RESP_OK : RESP_ERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Rate gate: ticks closer than the limit are dropped
    assign acc    = max_rate_tick && (gap_r == 8'h00);       // R4
    assign mask   = RATE_DIV_W'((32'h1 << act_r.rate) - 32'h1);
    assign smp_go = acc && ((div_r & mask) == mask);          // R3

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_r <= 8'h00;
        end else if (acc) begin
            gap_r <= 8'(MIN_GAP - 1);                         // R4
        end else if (gap_r != 8'h00) begin
            gap_r <= gap_r - 8'h01;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state_r == ST_OFF) begin
            div_r <= '0;
        end else if (acc) begin
            div_r <= div_r + RATE_DIV_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample assembly from one instant of all inputs
    always_comb begin
        val[0] = pick(demod_in.x_f, demod_in.x_q, act_r.fmt); // R2
        val[1] = pick(demod_in.y_f, demod_in.y_q, act_r.fmt);
        val[2] = pick(demod_in.r_f, demod_in.r_q, act_r.fmt);
        val[3] = pick(demod_in.t_f, demod_in.t_q, act_r.fmt);
        case (act_r.chan)                                     // R1
            CH_X:    nval = 3'h1;
            CH_XY:   nval = 3'h2;
            CH_RT: begin
                nval   = 3'h2;
                val[0] = val[2];
                val[1] = val[3];
            end
            default: nval = 3'h4;
        endcase
    end

    assign bpv    = (act_r.fmt == FMT_I16) ? 3'h2 : 3'h4;      // R6
    assign sbytes = 5'(nval) * 5'(bpv);
    assign hdr    = (dcnt_r == 11'h000);
    assign hoff   = hdr ? 5'(HDR_BYTES) : 5'h00;
    assign psize  = pkt_data_bytes(act_r.pkt);                // R8
    assign dcnt_nxt = dcnt_r + {6'h00, sbytes};
    assign pend   = (dcnt_nxt == psize);                      // R20

    always_comb begin
        int idx;
        int sh;
        idx = 0;
        sh  = 0;
        for (int i = 0; i < BUF_BYTES; i++) begin
            nb[i] = 8'h00;
        end
        // Header stays big-endian whatever the data order
        if (hdr) begin
            nb[0] = seq_r[15:8];                              // R19
            nb[1] = seq_r[7:0];
            nb[2] = {1'b0, act_r.fmt, act_r.pkt, act_r.chan, act_r.opt};
            nb[3] = {3'h0, act_r.rate};
        end
        for (int k = 0; k < 4; k++) begin
            for (int j = 0; j < 4; j++) begin
                if (k < int'(nval) && j < int'(bpv)) begin
                    idx = int'(hoff) + k * int'(bpv) + j;     // R20
                    sh  = act_r.opt[OPT_LE] ? j
                                            : int'(bpv) - 1 - j; // R12
                    nb[idx] = val[k][8*sh +: 8];
                end
            end
        end
    end

    // A sample that finds the serializer busy is lost, never resent
    assign busy = (ptr_r != len_r);
    assign take = smp_go && !busy &&
                  (state_r == ST_RUN ||
                   (state_r == ST_STOP && !hdr));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovr_r <= 16'h0000;
        end else if (state_r == ST_OFF && en_r) begin
            ovr_r <= 16'h0000;
        end else if (smp_go && busy && state_r != ST_OFF) begin
            ovr_r <= ovr_r + 16'h0001;                        // R10
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            len_r  <= 5'h00;
            pend_r <= 1'b0;
            for (int i = 0; i < BUF_BYTES; i++) begin
                buf_r[i] <= 8'h00;
            end
        end else if (take) begin
            len_r  <= hoff + sbytes;
            pend_r <= pend;
            for (int i = 0; i < BUF_BYTES; i++) begin
                buf_r[i] <= nb[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || state_r == ST_OFF) begin
            dcnt_r <= 11'h000;
            seq_r  <= 16'h0000;
        end else if (take) begin
            dcnt_r <= pend ? 11'h000 : dcnt_nxt;              // R20
            seq_r  <= pend ? seq_r + 16'h0001 : seq_r;        // R19
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Byte serializer toward the UDP engine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ptr_r    <= 5'h00;
            tx_valid <= 1'b0;
            tx_data  <= 8'h00;
            tx_last  <= 1'b0;
        end else if (take) begin
            ptr_r <= 5'h00;
            if (tx_ready) begin
                tx_valid <= 1'b0;
                tx_last  <= 1'b0;
            end
        end else if (!tx_valid || tx_ready) begin
            if (busy) begin
                ptr_r    <= ptr_r + 5'h01;
                tx_valid <= 1'b1;
                tx_data  <= buf_r[ptr_r];
                tx_last  <= pend_r && (ptr_r == len_r - 5'h01); // R20
            end else begin
                tx_valid <= 1'b0;
                tx_last  <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Settings are frozen into the active copy on each start
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r       <= ST_OFF;
            act_r         <= '0;
            tx_meta       <= '0;
            stream_active <= 1'b0;
        end else begin
            case (state_r)
                ST_OFF: begin
                    if (en_r) begin                           // R15
                        act_r         <= cfg_r;               // R16
                        tx_meta.ip    <= vxi_src_ip;          // R17
                        tx_meta.port  <= cfg_r.port;
                        tx_meta.len   <= pkt_data_bytes(cfg_r.pkt)
                                         + HDR_LEN;           // R9
                        tx_meta.csum  <= cfg_r.opt[OPT_CHK];  // R13
                        stream_active <= 1'b1;
                        state_r       <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    if (!en_r) begin                          // R15
                        state_r <= ST_STOP;
                    end
                end
                ST_STOP: begin
                    // Finish the open packet, then go idle
                    if (hdr && !busy && !tx_valid) begin
                        stream_active <= 1'b0;
                        state_r       <= ST_OFF;
                    end
                end
                default: state_r <= ST_OFF;
            endcase
        end
    end

endmodule : usp_stream_packetizer
`default_nettype wire

//--- dv/usp_rx_model.sv
`timescale 1ns/1ps
`default_nettype none
module usp_rx_model (
    input  wire logic       aclk,     // Clock
    input  wire logic       slow,     // Stall every other cycle
    input  wire logic       tx_valid, // Byte valid
    input  wire logic [7:0] tx_data,  // Byte
    input  wire logic       tx_last,  // Final byte
    output logic            tx_ready  // Accept
);
    logic [7:0] rx_q[$];
    int         len_q[$];
    int         cnt = 0;
    logic       ph  = 1'b0;
    assign tx_ready = ph;
    // Half-rate stalls still keep pace; nothing is ever asked again
    always @(posedge aclk) begin
        ph <= slow ? ~ph : 1'b1;
        if (tx_valid && tx_ready) begin
            rx_q.push_back(tx_data);
            cnt = cnt + 1;
            if (tx_last) begin
                len_q.push_back(cnt);
                cnt = 0;
            end
        end
    end
endmodule : usp_rx_model
`default_nettype wire

//--- dv/usp_properties.sv
`timescale 1ns/1ps
`default_nettype none
module usp_properties
    import usp_pkg::*;
(
    input wire logic       aclk,          // Clock
    input wire logic       aresetn,       // Reset
    input wire logic       s_axi_awvalid, // AW valid
    input wire logic       s_axi_awready, // AW ready
    input wire logic       s_axi_wvalid,  // W valid
    input wire logic       s_axi_wready,  // W ready
    input wire logic       s_axi_bvalid,  // B valid
    input wire logic       s_axi_bready,  // B ready
    input wire logic       tx_valid,      // Byte valid
    input wire logic [7:0] tx_data,       // Byte
    input wire logic       tx_last,       // Final byte
    input wire logic       tx_ready,      // Sink ready
    input wire usp_meta_t  tx_meta,       // Datagram meta
    input wire logic       stream_active  // Running
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
////////////////////////////////////////
    sequence s_wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_b_wait;
        s_axi_bvalid && !s_axi_bready;
    endsequence
    sequence s_tx_stall;
        tx_valid && !tx_ready;
    endsequence
    AST_B_ANSWER: assert property (s_wr_both |=> ##1 s_axi_bvalid)
        else $error("write response late");
    AST_B_HOLD: assert property (s_b_wait |=> s_axi_bvalid && !s_axi_awready)
        else $error("write response dropped");
    AST_TX_HOLD: assert property (
        s_tx_stall |=> tx_valid && $stable(tx_data) && $stable(tx_last)
    ) else $error("stalled byte changed");
    AST_META_HOLD: assert property (
        stream_active && $past(stream_active) |-> $stable(tx_meta)
    ) else $error("settings changed mid stream");
    AST_META_LEN: assert property (
        stream_active |->
            tx_meta.len inside {11'h084, 11'h104, 11'h204, 11'h404}
    ) else $error("bad payload length");
    AST_PORT: assert property (
        stream_active |-> tx_meta.port >= PORT_MIN
    ) else $error("port below range");
    AST_IDLE: assert property (!stream_active |-> !tx_valid)
        else $error("bytes sent while stopped");
    AST_LAST: assert property (tx_last |-> tx_valid)
        else $error("last flag without byte");
endmodule : usp_properties
bind usp_stream_packetizer usp_properties chk_u (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready), .tx_meta(tx_meta),
    .stream_active(stream_active)
);
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import usp_pkg::*;
;
    logic        aclk = 1'b0;
    logic        aresetn, awv, wv, bre, arv, rre, tick, slow;
    logic        awr, wrd, bv, arr, rv, txv, txl, txr, act;
    logic [1:0]  br, rr, rs;
    logic [3:0]  tc = 4'h0;
    logic [7:0]  awa, ara, txd;
    logic [31:0] wd, rd_d, ip, v;
    usp_meta_t   meta;
    usp_demod_t  dm;
    int          n_mismatch = 0;
    int          compares = 0;
    int          i;
    localparam logic [31:0] RST_V [9] = '{32'h0, 32'h0, 32'h0, 32'h0,
        32'h749, 32'h2, 32'h0, 32'h0001_3135, 32'h0};
    localparam logic [7:0] E1 [12] = '{8'h00, 8'h00, 8'h7d, 8'h01,
        8'h33, 8'h73, 8'hcd, 8'h8c, 8'hff, 8'h7f, 8'h00, 8'h80};
    localparam logic [7:0] E2 [12] = '{8'h00, 8'h00, 8'h32, 8'h00,
        8'h3f, 8'h80, 8'h00, 8'h00, 8'h3f, 8'h80, 8'h00, 8'h00};
    usp_stream_packetizer #(.MIN_GAP(8)) dut_u (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bre),
        .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rd_d), .s_axi_rresp(rr), .s_axi_rvalid(rv),
        .s_axi_rready(rre), .demod_in(dm), .max_rate_tick(tick),
        .max_rate_hz(32'h0001_3135), .vxi_src_ip(ip), .tx_valid(txv),
        .tx_data(txd), .tx_last(txl), .tx_ready(txr), .tx_meta(meta),
        .stream_active(act)
    );
    usp_rx_model rx_u (.aclk(aclk), .slow(slow), .tx_valid(txv),
        .tx_data(txd), .tx_last(txl), .tx_ready(txr));
////////////////////////////////////////
    always #25 aclk = ~aclk;
    // Tick every 16 cycles keeps well clear of the minimum gap
    always @(posedge aclk) begin
        tc <= tc + 4'h1;
        tick <= (tc == 4'h0);
    end
////////////////////////////////////////
    task automatic tally_and_finish;
        $display("mismatches=%0d compares=%0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : tally_and_finish
    task automatic tmo;
        n_mismatch++;
        tally_and_finish();
    endtask : tmo
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r);
        int k;
        @(posedge aclk);
        awa <= a;
        wd <= d;
        {awv, wv} <= 2'h3;
        for (k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrd) wv <= 1'b0;
            if (bv && bre) break;
            if (bv) bre <= 1'b1;
        end
        if (k == 100) tmo();
        r = br;
        bre <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        int k;
        @(posedge aclk);
        ara <= a;
        {arv, rre} <= 2'h3;
        for (k = 0; k < 100; k++) begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        if (k == 100) tmo();
        d = rd_d;
        r = rr;
        rre <= 1'b0;
    endtask : rd
    task automatic cfg(input logic [31:0] c, r, f, o);
        wr(REG_CHAN, c, rs);
        wr(REG_RATE, r, rs);
        wr(REG_FMT, f, rs);
        wr(REG_PKT, 32'h3, rs);
        wr(REG_OPT, o, rs);
        wr(REG_EN, 32'h1, rs);
    endtask : cfg
    task automatic wait_pk(input int n);
        int k;
        for (k = 0; k < 5000 && rx_u.len_q.size() < n; k++) @(posedge aclk);
        if (k == 5000) tmo();
    endtask : wait_pk
    task automatic wait_idle;
        int k;
        for (k = 0; k < 5000 && act !== 1'b0; k++) @(posedge aclk);
        if (k == 5000) tmo();
    endtask : wait_idle
////////////////////////////////////////
    initial begin
        aresetn = 1'b0;
        {awv, wv, bre, arv, rre, slow} = 6'h01;
        {awa, ara, wd} = 48'h0;
        ip = 32'h0a00_0001;
        // Full scale, negative full scale, and both saturation ends
        dm = '{32'h3f80_0000, 32'h4000_0000, 32'h4040_0000, 32'h4080_0000,
               24'h10_0000, 24'hf0_0000, 24'h40_0000, 24'hc0_0000};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (i = 0; i < 9; i++) begin
            rd(8'(4 * i), v, rs);
            chk(v, RST_V[i]);
        end
        rd(8'h24, v, rs);
        chk({v[29:0], rs}, 32'h2);
        wr(8'h24, 32'h1, rs);
        chk(32'(rs), 32'(RESP_ERR));
        wr(REG_RATE, 32'h19, rs);
        rd(REG_RATE, v, rs);
        chk(v, 32'h14);
        wr(REG_PORT, 32'h3ff, rs);
        rd(REG_PORT, v, rs);
        chk(v, 32'h749);
        wr(REG_PORT, 32'h3039, rs);
        rd(REG_PORT, v, rs);
        chk(v, 32'h3039);
        $display("test registers done");
        cfg(32'h3, 32'h1, 32'h1, 32'h1);
        repeat (2) @(posedge aclk);
        chk(32'(act), 32'h1);
        chk(32'(meta.len), 32'h84);
        chk(32'(meta.port), 32'h3039);
        chk(meta.ip, 32'h0a00_0001);
        chk(32'(meta.csum), 32'h0);
        ip <= 32'h0a00_0002;
        wr(REG_CHAN, 32'h0, rs);
        wait_pk(2);
        wr(REG_EN, 32'h0, rs);
        wait_idle();
        chk(rx_u.len_q[1], 32'h84);
        for (i = 0; i < 12; i++) chk(rx_u.rx_q[i], E1[i]);
        chk(rx_u.rx_q[133], 32'h1);
        chk(rx_u.rx_q[134], 32'h7d);
        $display("test int16 run done");
        rx_u.rx_q.delete();
        rx_u.len_q.delete();
        slow <= 1'b0;
        cfg(32'h0, 32'h0, 32'h0, 32'h2);
        wait_pk(1);
        chk(meta.ip, 32'h0a00_0002);
        chk(32'(meta.csum), 32'h1);
        for (i = 0; i < 12; i++) chk(rx_u.rx_q[i], E2[i]);
        wr(REG_EN, 32'h0, rs);
        wait_idle();
        $display("test float run done");
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
